// *** verilog/izs_pkg.sv ***
package izs_pkg;

    localparam logic [7:0]  IZS_ADDR_CTRL   = 8'h01;
    localparam logic [7:0]  IZS_ADDR_STATUS = 8'h1F;
    localparam logic [7:0]  IZS_CTRL_RESET  = 8'h00;

    localparam int          IZS_INTERP_HI   = 7;
    localparam int          IZS_INTERP_LO   = 6;
    localparam int          IZS_MODSEL_HI   = 5;
    localparam int          IZS_MODSEL_LO   = 4;
    localparam int          IZS_STUFF_BIT   = 3;
    localparam int          IZS_CMPLX_BIT   = 2;
    localparam int          IZS_NEGROT_BIT  = 1;

    localparam int          IZS_DW          = 16;
    localparam int          IZS_STAGES      = 3;
    localparam int          IZS_FIFO_DEPTH  = 2;

    localparam logic [15:0] IZS_MIDSCALE    = 16'h8000;
    localparam logic [17:0] IZS_COEF_ONE    = 18'h0_8000;
    localparam logic [17:0] IZS_COEF_R2     = 18'h0_5A82;
    localparam int          IZS_COEF_SHIFT  = 15;

    typedef enum logic [1:0] {
        IZS_MOD_NONE = 2'b00,
        IZS_MOD_HALF = 2'b01,
        IZS_MOD_QUAR = 2'b11,
        IZS_MOD_EIGH = 2'b10
    } izs_mod_e;

endpackage

// *** verilog/izs_fifo2.sv ***
`timescale 1ns/100ps
module izs_fifo2 #(
    parameter int W = 32
) (
    input  wire logic         clk_sys_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] wr_data_i,
    input  wire logic         wr_valid_i,
    output logic              wr_ready_o,
    output logic [W-1:0]      rd_data_o,
    output logic              rd_valid_o,
    input  wire logic         rd_ready_i
);

    typedef struct packed {
        logic [izs_pkg::IZS_FIFO_DEPTH-1:0][W-1:0] mem;
        logic                                      wptr;
        logic                                      rptr;
        logic [1:0]                                cnt;
    } izs_fifo_s;

    izs_fifo_s st;
    izs_fifo_s next_st;
    logic      push;
    logic      pop;

    assign wr_ready_o = (st.cnt != 2'd2);
    assign rd_valid_o = (st.cnt != 2'd0);
    assign rd_data_o  = st.mem[st.rptr];
    assign push       = wr_valid_i && wr_ready_o;
    assign pop        = rd_ready_i && rd_valid_o;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = wr_data_i;
            next_st.wptr         = ~st.wptr;
        end
        if (pop) begin
            next_st.rptr = ~st.rptr;
        end
        case ({push, pop})
            2'b10:   next_st.cnt = st.cnt + 2'd1;
            2'b01:   next_st.cnt = st.cnt - 2'd1;
            default: next_st.cnt = st.cnt;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// *** verilog/izs_datapath.sv ***
`timescale 1ns/100ps
module izs_datapath (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [7:0]       reg_rdata_o,
    input  wire logic [15:0] in_i_i,
    input  wire logic [15:0] in_q_i,
    input  wire logic        in_valid_i,
    output logic             in_ready_o,
    output logic [15:0]      dac_i_o,
    output logic [15:0]      dac_q_o,
    output logic             dac_valid_o,
    input  wire logic        dac_ready_i
);

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers.

    function automatic logic [15:0] half_sum(input logic [15:0] a, input logic [15:0] b);
        logic signed [16:0] s;
        s = $signed({a[15], a}) + $signed({b[15], b});
        return s[16:1];
    endfunction

    function automatic logic signed [17:0] mul_coef(input logic [15:0] x,
                                                    input logic signed [17:0] c);
        logic signed [33:0] p;
        p = $signed({{18{x[15]}}, x}) * $signed({{16{c[17]}}, c});
        return p[izs_pkg::IZS_COEF_SHIFT +: 18];
    endfunction

    function automatic logic [15:0] sat16(input logic signed [17:0] v);
        logic [15:0] r;
        r = v[15:0];
        if (v > 18'sh0_7FFF) begin
            r = 16'h7FFF;
        end else if (v < -18'sh0_8000) begin
            r = 16'h8000;
        end
        return r;
    endfunction

    // Carrier pattern for the chosen rate, indexed by the output step.
    function automatic logic signed [17:0] carrier(input logic [1:0] sel,
                                                   input logic [2:0] k);
        logic signed [17:0] one;
        logic signed [17:0] r2;
        logic signed [17:0] c;
        one = $signed(izs_pkg::IZS_COEF_ONE);
        r2  = $signed(izs_pkg::IZS_COEF_R2);
        c   = one;
        case (sel)
            izs_pkg::IZS_MOD_HALF: c = k[0] ? -one : one;
            izs_pkg::IZS_MOD_QUAR: begin
                case (k[1:0])
                    2'd1:    c = one;
                    2'd3:    c = -one;
                    default: c = '0;
                endcase
            end
            izs_pkg::IZS_MOD_EIGH: begin
                case (k)
                    3'd0:    c = '0;
                    3'd1:    c = r2;
                    3'd2:    c = one;
                    3'd3:    c = r2;
                    3'd4:    c = '0;
                    3'd5:    c = -r2;
                    3'd6:    c = -one;
                    default: c = -r2;
                endcase
            end
            default: c = one;
        endcase
        return c;
    endfunction

    // Mask of phase bits that must be zero for stage j to fire at factor 2^l.
    function automatic logic [2:0] stage_mask(input logic [1:0] l, input int j);
        logic [3:0] n;
        n = 4'd1 << l;
        return 3'((n >> (j + 1)) - 4'd1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [7:0]                   ctrl;
        logic [2:0]                   ph;
        logic [2:0]                   midx;
        logic                         stuff_ph;
        logic [2:0]                   odd;
        logic [2:0][1:0][15:0]        last;
        logic [2:0][1:0][15:0]        sout;
        logic [15:0]                  dac_i;
        logic [15:0]                  dac_q;
        logic                         dac_valid;
        logic [7:0]                   rdata;
    } izs_state_s;

    izs_state_s         st;
    izs_state_s         next_st;
    logic [31:0]        fifo_data;
    logic               fifo_valid;
    logic               fifo_pop;
    logic [1:0]         interp_l;
    logic [1:0]         mod_sel;
    logic               stuff_en;
    logic               cmplx_on;
    logic               need_input;
    logic               advance;
    logic [1:0][15:0]   chain_out;
    logic signed [17:0] c_sin;
    logic signed [17:0] c_cos;
    logic [2:0]         cos_idx;
    logic [15:0]        mod_i;
    logic [15:0]        mod_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Input buffer.

    izs_fifo2 #(
        .W (32)
    ) u_fifo (
        .clk_sys_i  (clk_sys_i),
        .nrst_i     (nrst_i),
        .wr_data_i  ({in_q_i, in_i_i}),
        .wr_valid_i (in_valid_i),
        .wr_ready_o (in_ready_o),
        .rd_data_o  (fifo_data),
        .rd_valid_o (fifo_valid),
        .rd_ready_i (fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode and pacing.

    assign interp_l = st.ctrl[izs_pkg::IZS_INTERP_HI:izs_pkg::IZS_INTERP_LO];
    assign mod_sel  = st.ctrl[izs_pkg::IZS_MODSEL_HI:izs_pkg::IZS_MODSEL_LO];
    assign stuff_en = st.ctrl[izs_pkg::IZS_STUFF_BIT];
    // Quadrature carriers do not exist at half rate, so coupling falls back to real.
    assign cmplx_on = st.ctrl[izs_pkg::IZS_CMPLX_BIT] &&
                      (mod_sel == izs_pkg::IZS_MOD_QUAR ||
                       mod_sel == izs_pkg::IZS_MOD_EIGH);

    // A new baseband sample is due when the first stage starts a new pair.
    assign need_input = !st.stuff_ph &&
                        ((interp_l == 2'd0) ||
                         (((st.ph & stage_mask(interp_l, 0)) == 3'd0) && !st.odd[0]));
    assign advance    = dac_ready_i && (!need_input || fifo_valid);
    assign fifo_pop   = advance && need_input;

    // The modulator sees the last active stage, or the raw sample when bypassed.
    always_comb begin
        chain_out[0] = fifo_data[15:0];
        chain_out[1] = fifo_data[31:16];
        if (interp_l != 2'd0) begin
            chain_out = st.sout[interp_l - 2'd1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Modulator.

    assign cos_idx = (mod_sel == izs_pkg::IZS_MOD_QUAR) ? st.midx + 3'd1 : st.midx + 3'd2;
    assign c_sin   = carrier(mod_sel, st.midx);
    assign c_cos   = carrier(mod_sel, cos_idx);

    always_comb begin
        logic signed [17:0] ic;
        logic signed [17:0] is;
        logic signed [17:0] qc;
        logic signed [17:0] qs;
        ic = mul_coef(chain_out[0], c_cos);
        is = mul_coef(chain_out[0], c_sin);
        qc = mul_coef(chain_out[1], c_cos);
        qs = mul_coef(chain_out[1], c_sin);
        // Real mode scales each channel by the carrier: half-rate at full
        // amplitude, quarter and eighth rate images halved by the zero taps.
        mod_i = sat16(is);
        mod_q = sat16(qs);
        if (cmplx_on) begin
            if (st.ctrl[izs_pkg::IZS_NEGROT_BIT]) begin
                mod_i = sat16(ic + qs);
                mod_q = sat16(qc - is);
            end else begin
                mod_i = sat16(ic - qs);
                mod_q = sat16(qc + is);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [1:0][15:0] stg_in;
        logic [2:0]       nmask;
        next_st           = st;
        next_st.dac_valid = advance;
        stg_in            = '0;
        nmask             = stage_mask(interp_l, -1);

        if (reg_wr_i && reg_addr_i == izs_pkg::IZS_ADDR_CTRL) begin
            next_st.ctrl = reg_wdata_i;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                izs_pkg::IZS_ADDR_CTRL:   next_st.rdata = st.ctrl;
                izs_pkg::IZS_ADDR_STATUS: next_st.rdata = {2'b00, !in_ready_o, fifo_valid,
                                                           st.stuff_ph, st.midx};
                default:                  next_st.rdata = 8'h00;
            endcase
        end

        if (advance) begin
            if (st.stuff_ph) begin
                next_st.dac_i    = izs_pkg::IZS_MIDSCALE;
                next_st.dac_q    = izs_pkg::IZS_MIDSCALE;
                next_st.stuff_ph = 1'b0;
            end else begin
                // Offset binary toward the DAC core, so midscale is the top bit alone.
                next_st.dac_i    = {~mod_i[15], mod_i[14:0]};
                next_st.dac_q    = {~mod_q[15], mod_q[14:0]};
                next_st.midx     = st.midx + 3'd1;
                next_st.ph       = (st.ph + 3'd1) & nmask;
                next_st.stuff_ph = stuff_en;
                for (int j = 0; j < izs_pkg::IZS_STAGES; j++) begin
                    if (j < int'(interp_l) &&
                        (st.ph & stage_mask(interp_l, j)) == 3'd0) begin
                        if (j == 0) begin
                            stg_in[0] = fifo_data[15:0];
                            stg_in[1] = fifo_data[31:16];
                        end else begin
                            stg_in = st.sout[(j > 0) ? j - 1 : 0];
                        end
                        next_st.odd[j] = ~st.odd[j];
                        if (!st.odd[j]) begin
                            next_st.last[j]    = stg_in;
                            next_st.sout[j][0] = half_sum(st.last[j][0], stg_in[0]);
                            next_st.sout[j][1] = half_sum(st.last[j][1], stg_in[1]);
                        end else begin
                            next_st.sout[j] = st.last[j];
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st       <= '0;
            st.ctrl  <= izs_pkg::IZS_CTRL_RESET;
            st.dac_i <= izs_pkg::IZS_MIDSCALE;
            st.dac_q <= izs_pkg::IZS_MIDSCALE;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign dac_i_o     = st.dac_i;
    assign dac_q_o     = st.dac_q;
    assign dac_valid_o = st.dac_valid;

endmodule

// *** sim/izs_datapath_chk.sv ***
`timescale 1ns/100ps
module izs_datapath_chk (
    input wire logic        clk_sys_i,
    input wire logic        nrst_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        in_valid_i,
    input wire logic        in_ready_o,
    input wire logic [15:0] dac_i_o,
    input wire logic [15:0] dac_q_o,
    input wire logic        dac_valid_o,
    input wire logic        dac_ready_i
);
    // Shadow of the control word, the stuffing phase and the carrier step.
    logic [7:0] ctl;
    logic       ph;
    logic [2:0] k;
    logic       mid;
    logic       zro;

    assign mid = dac_i_o == izs_pkg::IZS_MIDSCALE && dac_q_o == izs_pkg::IZS_MIDSCALE;
    assign zro = !ctl[3] && !ctl[2] && ((ctl[5:4] == izs_pkg::IZS_MOD_QUAR && !k[0])
                 || (ctl[5:4] == izs_pkg::IZS_MOD_EIGH && k[1:0] == 2'h0));

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctl <= 8'h00;
            ph  <= 1'b0;
            k   <= 3'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == izs_pkg::IZS_ADDR_CTRL)
                ctl <= reg_wdata_i;
            if (dac_valid_o && ctl[3])
                ph <= !ph;
            if (dac_valid_o && !(ctl[3] && ph))
                k <= k + 3'h1;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_acc;
        in_valid_i && in_ready_o && ctl[7:6] == 2'b00;
    endsequence
    sequence s_fill;
        (in_valid_i && in_ready_o && !dac_ready_i) [*2];
    endsequence

    a_ctrl_readback: assert property (
        reg_rd_i && !reg_wr_i && reg_addr_i == izs_pkg::IZS_ADDR_CTRL |=> reg_rdata_o == ctl)
        else $error("control readback differs");
    a_unmapped_read: assert property (
        reg_rd_i && reg_addr_i != izs_pkg::IZS_ADDR_CTRL
        && reg_addr_i != izs_pkg::IZS_ADDR_STATUS |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_stuff_midscale: assert property (
        dac_valid_o && ctl[3] && ph |-> mid)
        else $error("stuffed word not midscale");
    a_carrier_zero: assert property (
        dac_valid_o && zro |-> mid)
        else $error("zero carrier step not midscale");
    a_bypass_output: assert property (
        s_acc ##1 dac_ready_i [*2] |-> ##[0:1] dac_valid_o)
        else $error("accepted sample gave no output");
    a_stall_holds: assert property (
        !dac_ready_i |=> !dac_valid_o && $stable(dac_i_o) && $stable(dac_q_o))
        else $error("output moved during stall");
    a_full_refuse: assert property (
        s_fill |=> !in_ready_o)
        else $error("two held words but still ready");
    a_reset_idle: assert property (
        $rose(nrst_i) |-> !dac_valid_o && mid && in_ready_o)
        else $error("outputs not idle after reset");
endmodule

bind izs_datapath izs_datapath_chk u_chk (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .dac_i_o(dac_i_o), .dac_q_o(dac_q_o), .dac_valid_o(dac_valid_o),
    .dac_ready_i(dac_ready_i)
);

// *** sim/izs_bb_src.sv ***
`timescale 1ns/100ps
module izs_bb_src (
    input  wire logic   clk_sys_i,
    input  wire logic   in_ready_i,
    output logic [15:0] smp_i_o,
    output logic [15:0] smp_q_o,
    output logic        smp_valid_o
);
    int gap = 0;

    initial begin
        smp_i_o = 16'h0000;
        smp_q_o = 16'h0000;
        smp_valid_o = 1'b0;
    end

    // Released data is inverted so a stale word is never mistaken for a fresh one.
    task automatic idle();
        smp_valid_o <= 1'b0;
        smp_i_o <= ~smp_i_o;
        smp_q_o <= ~smp_q_o;
    endtask

    // Called just after an edge; the pair is held until the buffer takes it.
    task automatic push(input logic [15:0] si, input logic [15:0] sq);
        smp_i_o <= si;
        smp_q_o <= sq;
        smp_valid_o <= 1'b1;
        do @(posedge clk_sys_i);
        while (in_ready_i !== 1'b1);
        if (gap > 0) begin
            idle();
            repeat (gap) @(posedge clk_sys_i);
        end
    endtask
endmodule

// *** sim/izs_datapath_tb.sv ***
`timescale 1ns/100ps
module izs_datapath_tb;
    logic        clk_sys_i;
    logic        nrst_i;
    logic [7:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [7:0]  reg_rdata_o;
    logic [15:0] in_i_i;
    logic [15:0] in_q_i;
    logic        in_valid_i;
    logic        in_ready_o;
    logic [15:0] dac_i_o;
    logic [15:0] dac_q_o;
    logic        dac_valid_o;
    logic        dac_ready_i = 1'b1;
    logic [1:0]  rdy_mode = 2'h0;
    logic [7:0]  rv;
    logic [31:0] got[$];
    logic [31:0] smp[8] = '{32'h1234_0F00, 32'hF000_2000, 32'h0400_C000, 32'h7000_0123,
                            32'hA000_5000, 32'h0010_FFF0, 32'h3FFF_8001, 32'hC001_7FFF};
    int          n_fail = 0;
    int          checks = 0;

    izs_datapath dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .in_i_i(in_i_i), .in_q_i(in_q_i),
        .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .dac_i_o(dac_i_o),
        .dac_q_o(dac_q_o), .dac_valid_o(dac_valid_o), .dac_ready_i(dac_ready_i));
    izs_bb_src u_src (
        .clk_sys_i(clk_sys_i), .in_ready_i(in_ready_o), .smp_i_o(in_i_i),
        .smp_q_o(in_q_i), .smp_valid_o(in_valid_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode 1 toggles the DAC acceptance every cycle, mode 2 stalls it.
    always @(posedge clk_sys_i) begin
        dac_ready_i <= rdy_mode == 2'h2 ? 1'b0 : rdy_mode == 2'h1 ? ~dac_ready_i : 1'b1;
        if (dac_valid_o === 1'b1)
            got.push_back({dac_i_o, dac_q_o});
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        d = reg_rdata_o;
    endtask

    task automatic rst();
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        got.delete();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Sine coefficient scaled by the unit coefficient; mode none passes through.
    function automatic int cf(input logic [1:0] m, input int k);
        int one;
        int r2;
        one = int'(izs_pkg::IZS_COEF_ONE);
        r2 = int'(izs_pkg::IZS_COEF_R2);
        case (m)
            izs_pkg::IZS_MOD_HALF: return k % 2 ? -one : one;
            izs_pkg::IZS_MOD_QUAR: return k % 4 == 1 ? one : k % 4 == 3 ? -one : 0;
            izs_pkg::IZS_MOD_EIGH: return k % 4 == 0 ? 0 : (k % 4 == 2 ? one : r2)
                                          * (k % 8 > 4 ? -1 : 1);
            default: return one;
        endcase
    endfunction

    function automatic logic [31:0] expv(input logic [7:0] c, input logic [31:0] x,
                                         input int k);
        int a, b, s, co, g, i, q;
        a = int'($signed(x[31:16]));
        b = int'($signed(x[15:0]));
        s = cf(c[5:4], k);
        co = cf(c[5:4], k + (c[4] ? 1 : 2));
        g = c[1] ? -1 : 1;
        if (c[2] && c[5]) begin
            i = (a * co - g * b * s) >>> izs_pkg::IZS_COEF_SHIFT;
            q = (b * co + g * a * s) >>> izs_pkg::IZS_COEF_SHIFT;
        end else begin
            i = (a * s) >>> izs_pkg::IZS_COEF_SHIFT;
            q = (b * s) >>> izs_pkg::IZS_COEF_SHIFT;
        end
        return {16'(i) ^ izs_pkg::IZS_MIDSCALE, 16'(q) ^ izs_pkg::IZS_MIDSCALE};
    endfunction

    task automatic run(input logic [7:0] c);
        rst();
        wr(izs_pkg::IZS_ADDR_CTRL, c);
        foreach (smp[j]) u_src.push(smp[j][31:16], smp[j][15:0]);
        u_src.idle();
        repeat (80) @(posedge clk_sys_i);
        check(32'(got.size()), c[3] ? 32'h10 : 32'h8);
        foreach (smp[j]) begin
            check(got[j << c[3]], expv(c, smp[j], j));
            if (c[3])
                check(got[2 * j + 1], {2{izs_pkg::IZS_MIDSCALE}});
        end
    endtask

    task automatic interp(input logic [7:0] c, input int f);
        rst();
        wr(izs_pkg::IZS_ADDR_CTRL, c);
        repeat (8) u_src.push(16'h2000, 16'hE000);
        u_src.idle();
        repeat (200) @(posedge clk_sys_i);
        check(32'(got.size() >= 5 * f && got.size() <= 8 * f), 32'h1);
        if (!c[3])
            check(got[$], 32'hA000_6000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(izs_pkg::IZS_ADDR_CTRL, rv);
        check(32'(rv), 32'h0);
        wr(izs_pkg::IZS_ADDR_CTRL, 8'hFF);
        rd(izs_pkg::IZS_ADDR_CTRL, rv);
        check(32'(rv), 32'hFF);
        wr(8'h02, 8'h00);
        rd(izs_pkg::IZS_ADDR_CTRL, rv);
        check(32'(rv), 32'hFF);
        rd(8'h05, rv);
        check(32'(rv), 32'h0);
        rst();
        rdy_mode <= 2'h2;
        repeat (2) @(posedge clk_sys_i);
        repeat (2) u_src.push(16'h0100, 16'h0200);
        u_src.idle();
        rd(izs_pkg::IZS_ADDR_STATUS, rv);
        check(32'(rv[5:4]), 32'h3);
        check(32'(in_ready_o), 32'h0);
        rdy_mode <= 2'h1;
        repeat (10) @(posedge clk_sys_i);
        rd(izs_pkg::IZS_ADDR_STATUS, rv);
        check(32'(rv[4]), 32'h0);
        rdy_mode <= 2'h0;
        run(8'h00);
        rdy_mode <= 2'h1;
        run(8'h10);
        u_src.gap = 1;
        run(8'h30);
        run(8'h20);
        run(8'h38);
        u_src.gap = 0;
        run(8'h34);
        run(8'h36);
        run(8'h14);
        interp(8'h40, 2);
        interp(8'h80, 4);
        rdy_mode <= 2'h0;
        interp(8'hC0, 8);
        interp(8'h48, 4);
        give_verdict();
    end

    // The whole sequence needs a few thousand cycles; this is far beyond it.
    initial begin
        #200us;
        n_fail++;
        give_verdict();
    end
endmodule
